/* File: fpcl_console.sv */
/*
  Front-panel console controller: switches and lamps on one side, the
  processor bus (strobes, cycle status, shared info bus) of two processors on
  the other. Assumes all processor and switch pins are asynchronous to i_mclk
  and that strobes last several i_mclk periods.
*/
// Notes on behaviour
// - low request pulse starts automatic program load
// - bus bits 5 and 6 read high during automatic program load
// - sr-latch debounce, then encode to console code
// - address latch captures on every address strobe
// - data latch captures except on code reads
// - data switches driven only on console reads
// - press raises request; code read releases it
// - single-step: continue then halt, extra state
// - select switch picks one of two processors
// - momentary switches latched; level switches sampled
// - every processor console operation is issuable
// - status 110 code read, 111 data transfer
// - operations encoded as 9-bit console code
// - step: continue, after fetch new request halt
`timescale 1ns/100ps
module fpcl_console
  import fpcl_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_addr_strobe_n,
  input wire logic i_data_strobe_n,
  input wire logic i_wr_n,
  input wire logic [2:0] i_status0,
  input wire logic [2:0] i_status1,
  input wire logic [BUS_W-1:0] i_bus,
  output logic [BUS_W-1:0] o_bus,
  output logic o_bus_oe,
  output logic [1:0] o_con_req_n,
  input wire logic [N_OPS-1:0] i_op_sw_no_n,
  input wire logic [N_OPS-1:0] i_op_sw_nc_n,
  input wire logic [BUS_W-1:0] i_data_sw,
  input wire logic i_cpu_sel,
  output logic [BUS_W-1:0] o_addr_lamp,
  output logic [BUS_W-1:0] o_data_lamp
);

  // ****************************************
  // pin synchronisers
  // ****************************************
  localparam int PIN_W = 10 + 2 * N_OPS + 2 * BUS_W;
  logic [PIN_W-1:0] pin_raw, pin_s1, pin_s2;
  logic [BUS_W-1:0] bus_s, bus_q, data_sw_s;
  logic [N_OPS-1:0] no_s, nc_s;
  logic [2:0] st0_s, st1_s;
  logic addr_n_s, data_n_s, wr_n_s, sel_s;

  assign pin_raw = {i_addr_strobe_n, i_data_strobe_n, i_wr_n, i_status0, i_status1,
                    i_cpu_sel, i_op_sw_no_n, i_op_sw_nc_n, i_data_sw, i_bus};
  assign {addr_n_s, data_n_s, wr_n_s, st0_s, st1_s, sel_s, no_s, nc_s,
          data_sw_s, bus_s} = pin_s2;

  always_ff @(posedge i_mclk) begin
    pin_s1 <= pin_raw;
    pin_s2 <= pin_s1;
    bus_q <= bus_s;
  end

  // ****************************************
  // cycle decode
  // ****************************************
  fpcl_cyc_t cyc, cyc_q;
  logic a_end, d_end, code_rd, data_rd;

  always_comb begin
    cyc.addr_stb = ~addr_n_s;
    cyc.data_stb = ~data_n_s;
    cyc.rd = wr_n_s;
    cyc.status = sel_s ? st1_s : st0_s;
  end

  // capture at strobe release so the bus sample has settled
  assign a_end = cyc_q.addr_stb & ~cyc.addr_stb;
  assign d_end = cyc_q.data_stb & ~cyc.data_stb;
  assign code_rd = cyc.data_stb & (cyc.status == ST_CODE_RD);
  assign data_rd = cyc.data_stb & cyc.rd & (cyc.status == ST_CON_DATA);

  // ****************************************
  // state
  // ****************************************
  logic [N_OPS-1:0] deb, deb_q, next_deb, press;
  logic [OP_W-1:0] op, next_op, press_op;
  logic req, next_req, any_press;
  fpcl_step_t step, next_step;
  logic [BUS_W-1:0] next_bus, next_addr_lamp, next_data_lamp;
  logic next_bus_oe;
  logic [1:0] next_con_req_n;

  // lowest-numbered switch wins when two are pressed together
  always_comb begin
    press_op = OP_LOAD;
    for (int i = N_OPS - 1; i >= 0; i--) begin
      if (press[i]) begin
        press_op = OP_W'(i);
      end
    end
  end

  assign press = deb & ~deb_q;
  assign any_press = |press;

  always_comb begin
    next_deb = ~no_s | (deb & nc_s);
    next_op = op;
    next_req = req;
    next_step = step;
    if (d_end && cyc_q.status == ST_CODE_RD) begin
      next_req = 1'b0;
      if (step == SS_CONT) begin
        next_step = SS_FETCH;
      end
    end
    if (step == SS_FETCH && a_end && cyc_q.status != ST_CODE_RD) begin
      next_req = 1'b1;
      next_op = OP_HALT;
      next_step = SS_IDLE;
    end
    // a fresh press overrides a clear in the same cycle
    if (any_press) begin
      next_req = 1'b1;
      next_op = (press_op == OP_STEP) ? OP_CONT : press_op;
      next_step = (press_op == OP_STEP) ? SS_CONT : SS_IDLE;
    end
    case (step)
      SS_IDLE, SS_CONT, SS_FETCH: ;
      default: next_step = SS_IDLE;
    endcase
  end

  always_comb begin
    next_addr_lamp = a_end ? bus_q : o_addr_lamp;
    next_data_lamp = o_data_lamp;
    if (d_end && cyc_q.status != ST_CODE_RD) begin
      next_data_lamp = bus_q;
    end
    next_bus_oe = code_rd | data_rd;
    next_bus = o_bus;
    if (code_rd) begin
      next_bus = {CODE_PAD, fpcl_code(op)};
    end else if (data_rd) begin
      next_bus = data_sw_s;
    end
    next_con_req_n = 2'h3;
    next_con_req_n[sel_s] = ~req;
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      deb <= '0;
      deb_q <= '0;
      op <= OP_LOAD;
      req <= 1'b0;
      step <= SS_IDLE;
      cyc_q <= '0;
      o_addr_lamp <= '0;
      o_data_lamp <= '0;
      o_bus <= '0;
      o_bus_oe <= 1'b0;
      o_con_req_n <= 2'h3;
    end else begin
      deb <= next_deb;
      deb_q <= deb;
      op <= next_op;
      req <= next_req;
      step <= next_step;
      cyc_q <= cyc;
      o_addr_lamp <= next_addr_lamp;
      o_data_lamp <= next_data_lamp;
      o_bus <= next_bus;
      o_bus_oe <= next_bus_oe;
      o_con_req_n <= next_con_req_n;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  property p_addr_cap;
    a_end |=> o_addr_lamp == $past(bus_q);
  endproperty
  a_addr_cap: assert property (p_addr_cap) else $error("address lamp missed capture");

  property p_data_cap;
    d_end && cyc_q.status != ST_CODE_RD |=> o_data_lamp == $past(bus_q);
  endproperty
  a_data_cap: assert property (p_data_cap) else $error("data lamp missed capture");

  property p_data_keep;
    d_end && cyc_q.status == ST_CODE_RD |=> $stable(o_data_lamp);
  endproperty
  a_data_keep: assert property (p_data_keep) else $error("code read changed data lamp");

  property p_sw_drive;
    data_rd |=> o_bus_oe && o_bus == $past(data_sw_s);
  endproperty
  a_sw_drive: assert property (p_sw_drive) else $error("switches not on bus");

  property p_no_drive;
    !code_rd && !data_rd |=> !o_bus_oe;
  endproperty
  a_no_drive: assert property (p_no_drive) else $error("bus driven outside console read");

  property p_req_set;
    any_press |=> req ##1 o_con_req_n[$past(sel_s)] == 1'b0;
  endproperty
  a_req_set: assert property (p_req_set) else $error("press did not raise request");

  property p_req_clr;
    d_end && cyc_q.status == ST_CODE_RD && !any_press && step != SS_FETCH |=> !req;
  endproperty
  a_req_clr: assert property (p_req_clr) else $error("code read left request up");

  property p_route;
    ##1 o_con_req_n[~$past(sel_s)] == 1'b1;
  endproperty
  a_route: assert property (p_route) else $error("request reached unselected cpu");

  sequence s_step_start;
    any_press && press_op == OP_STEP;
  endsequence
  sequence s_fetch_seen;
    step == SS_FETCH && a_end && cyc_q.status != ST_CODE_RD && !any_press;
  endsequence

  property p_step_cont;
    s_step_start |=> op == OP_CONT && step == SS_CONT && req;
  endproperty
  a_step_cont: assert property (p_step_cont) else $error("step did not issue continue");

  property p_step_halt;
    s_fetch_seen |=> req && op == OP_HALT && step == SS_IDLE;
  endproperty
  a_step_halt: assert property (p_step_halt) else $error("step did not follow with halt");

endmodule

/* File: fpcl_console_test.sv */
/*
  Self-checking bench for the console controller.
  Assumes the processor model file and the design package are compiled first.
*/
`timescale 1ns/100ps
module fpcl_console_test;
  import fpcl_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic as_n, ds_n, wr_n, sel = 1'b0, d_oe;
  logic [2:0] st0, st1;
  logic [1:0] req_n;
  logic [N_OPS-1:0] no_n = 8'hFF;
  logic [N_OPS-1:0] nc_n = 8'h00;
  logic [BUS_W-1:0] d_bus, m_bus, alamp, dlamp, got;
  logic [BUS_W-1:0] dsw = 16'h0000;
  logic [CODE_W-1:0] codes [N_OPS] = '{CODE_LOAD, CODE_TEST, CODE_CONT, CODE_HALT,
    CODE_CONT, CODE_EXAM, CODE_DEP, CODE_RESET};
  wire [BUS_W-1:0] bus = d_oe ? d_bus : m_bus;
  int errors = 0;
  int compares = 0;

  fpcl_console fpcl_console_inst (.i_mclk(mclk), .i_rst_n(rst_n), .i_addr_strobe_n(as_n),
    .i_data_strobe_n(ds_n), .i_wr_n(wr_n), .i_status0(st0), .i_status1(st1), .i_bus(bus),
    .o_bus(d_bus), .o_bus_oe(d_oe), .o_con_req_n(req_n), .i_op_sw_no_n(no_n),
    .i_op_sw_nc_n(nc_n), .i_data_sw(dsw), .i_cpu_sel(sel), .o_addr_lamp(alamp),
    .o_data_lamp(dlamp));
  fpcl_cpu_model fpcl_cpu_model_inst (.i_mclk(mclk), .i_bus(bus), .o_addr_strobe_n(as_n),
    .o_data_strobe_n(ds_n), .o_wr_n(wr_n), .o_status0(st0), .o_status1(st1), .o_bus(m_bus));

  // ****************************************
  // shared tasks
  // ****************************************
  task check(input logic [BUS_W-1:0] seen, input logic [BUS_W-1:0] exp, input string msg);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  task final_report;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task cyc(input logic dph, input logic who, input logic [2:0] st, input logic wr,
      input logic [BUS_W-1:0] val);
    fpcl_cpu_model_inst.bus_cycle(dph, who, st, wr, val, got);
  endtask
  // bounded wait, since the press passes a synchroniser and a latch first
  task wait_req(input logic lvl);
    for (int i = 0; i < 20 && req_n[sel] !== lvl; i++) begin
      @(negedge mclk);
    end
    check(req_n[sel], lvl, "request level");
  endtask
  task press(input int op);
    @(negedge mclk);
    no_n[op] = 1'b0;
    nc_n[op] = 1'b1;
    repeat (6) @(negedge mclk);
    no_n[op] = 1'b1;
    nc_n[op] = 1'b0;
    wait_req(1'b0);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task t_reset;
    check(d_oe, 1'b0, "reset bus enable");
    check(req_n, 2'h3, "reset request");
    check(alamp | dlamp, 16'h0000, "reset lamps");
    cyc(1'b1, 1'b0, ST_CODE_RD, 1'b1, 16'h0000);
    check(got, {CODE_PAD, CODE_LOAD}, "default load code");
    $display("test reset done");
  endtask
  task t_lamps;
    cyc(1'b0, 1'b0, 3'h0, 1'b0, 16'hA5C3);
    check(alamp, 16'hA5C3, "address lamp");
    cyc(1'b1, 1'b0, 3'h0, 1'b0, 16'h3C5A);
    check(dlamp, 16'h3C5A, "data lamp");
    cyc(1'b1, 1'b0, ST_CON_DATA, 1'b0, 16'h1234);
    check(got, 16'h1234, "no drive on console write");
    check(dlamp, 16'h1234, "data lamp on console write");
    dsw = 16'hBEEF;
    cyc(1'b1, 1'b0, ST_CON_DATA, 1'b1, 16'h0000);
    check(got, 16'hBEEF, "data switches");
    check(dlamp, 16'hBEEF, "data lamp on console read");
    $display("test lamps done");
  endtask
  task t_ops;
    for (int op = 0; op < N_OPS; op++) begin
      if (op != 4) begin
        press(op);
        // processor keeps re-reading the code while the request stays low
        for (int n = 0; n < 3 && req_n[sel] === 1'b0; n++) begin
          cyc(1'b1, 1'b0, ST_CODE_RD, 1'b1, 16'h0000);
        end
        check(got, {CODE_PAD, codes[op]}, "console code");
        check(dlamp, 16'hBEEF, "lamp kept on code read");
        check(req_n, 2'h3, "request released");
      end
    end
    $display("test ops done");
  endtask
  task t_step;
    press(4);
    cyc(1'b1, 1'b0, ST_CODE_RD, 1'b1, 16'h0000);
    check(got, {CODE_PAD, CODE_CONT}, "step continue");
    cyc(1'b0, 1'b0, 3'h0, 1'b0, 16'h0100);
    wait_req(1'b0);
    cyc(1'b1, 1'b0, ST_CODE_RD, 1'b1, 16'h0000);
    check(got, {CODE_PAD, CODE_HALT}, "step halt");
    $display("test step done");
  endtask
  task t_sel;
    sel = 1'b1;
    press(3);
    check(req_n, 2'h1, "request routed");
    cyc(1'b1, 1'b0, ST_CODE_RD, 1'b1, 16'h0000);
    check(req_n, 2'h1, "other processor ignored");
    cyc(1'b1, 1'b1, ST_CODE_RD, 1'b1, 16'h0000);
    check(got, {CODE_PAD, CODE_HALT}, "selected code");
    check(req_n, 2'h3, "request released");
    $display("test select done");
  endtask

  initial begin
    forever #5 mclk = ~mclk;
  end
  initial begin
    #500000;
    errors++;
    final_report;
  end
  initial begin
    repeat (3) @(negedge mclk);
    rst_n = 1'b1;
    repeat (2) @(negedge mclk);
    t_reset;
    t_lamps;
    t_ops;
    t_step;
    t_sel;
    final_report;
  end
endmodule

/* File: fpcl_cpu_model.sv */
/*
  Processor model for the console bench: strobes, cycle status, info bus.
  Assumes the bench resolves the shared bus and calls bus_cycle.
*/
`timescale 1ns/100ps
module fpcl_cpu_model
  import fpcl_pkg::*;
(
  input wire logic i_mclk,
  input wire logic [BUS_W-1:0] i_bus,
  output logic o_addr_strobe_n = 1'b1,
  output logic o_data_strobe_n = 1'b1,
  output logic o_wr_n = 1'b1,
  output logic [2:0] o_status0 = 3'h0,
  output logic [2:0] o_status1 = 3'h0,
  output logic [BUS_W-1:0] o_bus = 16'h0060
);
  task automatic bus_cycle(input logic dph, input logic who, input logic [2:0] st,
      input logic wr, input logic [BUS_W-1:0] val, output logic [BUS_W-1:0] got);
    @(negedge i_mclk);
    o_status0 = who ? 3'h0 : st;
    o_status1 = who ? st : 3'h0;
    o_wr_n = wr;
    if (!wr) begin
      o_bus = val;
    end
    @(negedge i_mclk);
    if (dph) begin
      o_data_strobe_n = 1'b0;
    end else begin
      o_addr_strobe_n = 1'b0;
    end
    repeat (8) @(negedge i_mclk);
    got = i_bus;
    o_addr_strobe_n = 1'b1;
    o_data_strobe_n = 1'b1;
    repeat (6) @(negedge i_mclk);
    // released bus: inverse of last value, bits 5 and 6 pulled up
    o_bus = ~o_bus | 16'h0060;
    o_status0 = 3'h0;
    o_status1 = 3'h0;
  endtask
endmodule

/* File: fpcl_pkg.sv */
/*
  Shared constants and types for the front-panel console controller.
  Assumes one system clock and a synchronous, active-low reset in the user.
*/
package fpcl_pkg;

  // ****************************************
  // widths and counts
  // ****************************************
  localparam int BUS_W = 16;
  localparam int CODE_W = 9;
  localparam int N_OPS = 8;
  localparam int OP_W = 3;

  // ****************************************
  // cycle-type status codes
  // ****************************************
  localparam logic [2:0] ST_CODE_RD = 3'h6;
  localparam logic [2:0] ST_CON_DATA = 3'h7;

  // ****************************************
  // operation switch indices
  // ****************************************
  localparam logic [OP_W-1:0] OP_LOAD = 3'h0;
  localparam logic [OP_W-1:0] OP_TEST = 3'h1;
  localparam logic [OP_W-1:0] OP_CONT = 3'h2;
  localparam logic [OP_W-1:0] OP_HALT = 3'h3;
  localparam logic [OP_W-1:0] OP_STEP = 3'h4;
  localparam logic [OP_W-1:0] OP_EXAM = 3'h5;
  localparam logic [OP_W-1:0] OP_DEP = 3'h6;
  localparam logic [OP_W-1:0] OP_RESET = 3'h7;

  // ****************************************
  // console codes (load keeps bus bits 5 and 6 high)
  // ****************************************
  localparam logic [CODE_W-1:0] CODE_LOAD = 9'h060;
  localparam logic [CODE_W-1:0] CODE_TEST = 9'h001;
  localparam logic [CODE_W-1:0] CODE_CONT = 9'h002;
  localparam logic [CODE_W-1:0] CODE_HALT = 9'h004;
  localparam logic [CODE_W-1:0] CODE_EXAM = 9'h008;
  localparam logic [CODE_W-1:0] CODE_DEP = 9'h010;
  localparam logic [CODE_W-1:0] CODE_RESET = 9'h100;
  localparam logic [BUS_W-CODE_W-1:0] CODE_PAD = 7'h00;

  // ****************************************
  // types
  // ****************************************
  typedef struct packed {
    logic addr_stb;
    logic data_stb;
    logic rd;
    logic [2:0] status;
  } fpcl_cyc_t;

  typedef enum logic [2:0] {
    SS_IDLE = 3'h1,
    SS_CONT = 3'h2,
    SS_FETCH = 3'h4
  } fpcl_step_t;

  function automatic logic [CODE_W-1:0] fpcl_code(input logic [OP_W-1:0] op);
    case (op)
      OP_TEST: fpcl_code = CODE_TEST;
      OP_CONT: fpcl_code = CODE_CONT;
      OP_HALT: fpcl_code = CODE_HALT;
      OP_EXAM: fpcl_code = CODE_EXAM;
      OP_DEP: fpcl_code = CODE_DEP;
      OP_RESET: fpcl_code = CODE_RESET;
      default: fpcl_code = CODE_LOAD;
    endcase
  endfunction

endpackage
